// [inc/uhp_pkg.sv]
// Shared constants and types of the universal host port.
// Assumes one device clock; host pins arrive synchronous to it.
package uhp_pkg;

  // ------------------------------------------------------------
  // Access type codes
  // ------------------------------------------------------------
  localparam logic [1:0] ACC_CTRL     = 2'h0;
  localparam logic [1:0] ACC_DATA_INC = 2'h1;
  localparam logic [1:0] ACC_ADDR     = 2'h2;
  localparam logic [1:0] ACC_DATA     = 2'h3;

  // ------------------------------------------------------------
  // Field positions and masks
  // ------------------------------------------------------------
  localparam int          HWORD_ID_BIT  = 16;
  localparam logic [31:0] HCR_CPU_INT   = 32'h0000_0002;
  localparam logic [31:0] HCR_HOST_INT  = 32'h0000_0004;
  localparam logic [31:0] STEP_BYTE     = 32'h0000_0004;
  localparam logic [31:0] STEP_WORD     = 32'h0000_0001;
  localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
  localparam logic [15:0] HALF_ZERO     = 16'h0000;
  localparam logic [3:0]  BE_ALL        = 4'hF;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic page_mode;
    logic nonmux_select;
    logic fullword;
    logic address_type_select;
    logic upper_gpio;
  } uhp_cfg_t;

  typedef struct packed {
    logic [7:0] page_addr_top_byte;
    logic [7:0] page_addr_upper_mid_byte;
  } uhp_page_t;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } uhp_mem_req_t;

  typedef struct packed {
    logic [1:0] acc;
    logic       read;
    logic       second_half;
    logic [3:0] be;
  } uhp_host_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WR_HOLD,
    ST_PUSH,
    ST_RD_WAIT,
    ST_DRIVE
  } uhp_state_t;

endpackage

// [hw/uhp_req_buf.sv]
// Two-entry request buffer between host port and internal memory.
// Assumes one clock; drain side may stall at any time.
`timescale 1ns/1ps
`default_nettype none
module uhp_req_buf (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire uhp_pkg::uhp_mem_req_t in_data,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output uhp_pkg::uhp_mem_req_t      out_data
);
  import uhp_pkg::*;

  // ------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------
  uhp_mem_req_t mem_q [2];
  logic [1:0]   count_q;
  logic         rd_ptr_q;
  logic         wr_ptr_q;
  logic         push_w;
  logic         pop_w;

  assign in_ready  = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push_w    = in_valid & in_ready;
  assign pop_w     = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (push_w) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q  <= 2'h0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
    end else begin
      if (push_w) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop_w) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push_w && !pop_w) begin
        count_q <= count_q + 2'h1;
      end else if (pop_w && !push_w) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule
`default_nettype wire

// [hw/uhp_host_port.sv]
// Universal host port: host bus front end to internal memory.
// Assumes host pins are synchronous to clock and memory answers reads in order.
`timescale 1ns/1ps
`default_nettype none
module uhp_host_port (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire uhp_pkg::uhp_cfg_t port_config_reg,
  input  wire uhp_pkg::uhp_page_t page_addr,
  input  wire logic              host_chip_select_n,
  input  wire logic [1:0]        host_data_strobes,
  input  wire logic [1:0]        access_type_select,
  input  wire logic              host_read_not_write,
  input  wire logic [3:0]        host_byte_enables_n,
  input  wire logic [15:0]       host_address_bus,
  input  wire logic [31:0]       host_data_in,
  output logic [31:0]            host_data_out,
  output logic [31:0]            host_data_oe_n,
  output logic                   host_ready_out,
  output logic                   interrupt_to_host,
  input  wire logic              cpu_int_to_host_set,
  output logic                   host_int_to_cpu,
  input  wire logic              cpu_int_clear,
  output logic [31:0]            host_addr_value,
  output uhp_pkg::uhp_mem_req_t  mem_req,
  output logic                   mem_req_valid,
  input  wire logic              mem_req_ready,
  input  wire logic              mem_rsp_valid,
  input  wire logic [31:0]       mem_rsp_rdata,
  input  wire logic              ext_mem_init_done,
  input  wire logic              ext_mem_drive_req,
  input  wire logic [15:0]       ext_mem_upper_data,
  output logic [15:0]            ext_mem_upper_data_out,
  output logic [15:0]            ext_mem_upper_oe_n,
  output logic                   ext_mem_upper_blocked
);
  import uhp_pkg::*;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [31:0] int_addr(
    input logic [31:0] a,
    input uhp_cfg_t    c,
    input uhp_page_t   p
  );
    logic [31:0] b;
    b = c.address_type_select ? a : {a[29:0], 2'b00};
    if (c.nonmux_select || c.page_mode) begin
      b[31:16] = {p.page_addr_top_byte, p.page_addr_upper_mid_byte};
    end
    return b;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  uhp_state_t    state_q, state_d;
  uhp_host_ctl_t ctl_q, ctl_d;
  uhp_mem_req_t  req_q, req_d;
  logic [31:0]   addr_q, addr_d;
  logic [15:0]   na_q, na_d;
  logic [15:0]   hold_lo_q, hold_lo_d;
  logic [1:0]    hold_be_q, hold_be_d;
  logic [31:0]   rd_word_q, rd_word_d;
  logic [31:0]   hd_out_q, hd_out_d;
  logic          drive_q, drive_d;
  logic          cpu_int_q, cpu_int_d;
  logic          host_int_q, host_int_d;
  logic          served_q;
  logic [31:0]   hd_in_q;
  logic [15:0]   emu_out_q;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  uhp_host_ctl_t ctl_w;
  logic          strobe_w;
  logic          start_w;
  logic          half_w;
  logic          nonmux_w;
  logic          allowed_w;
  logic          busy_w;
  logic          word_done_w;
  logic          incr_w;
  logic          buf_in_ready;
  logic [31:0]   step_w;
  logic [31:0]   next_addr_w;
  logic [31:0]   rd_addr_w;
  logic [31:0]   wr_addr_w;
  logic [31:0]   ctrl_word_w;
  logic [31:0]   wr_word_w;
  logic [3:0]    wr_be_w;
  logic          upper_en_w;

  assign strobe_w = ~host_chip_select_n
                  & (host_data_strobes[1] ^ host_data_strobes[0]);
  assign start_w  = strobe_w & ~served_q & port_config_reg.enable
                  & (state_q == ST_IDLE);
  assign nonmux_w = port_config_reg.nonmux_select;
  assign half_w   = ~nonmux_w & ~port_config_reg.fullword;
  assign allowed_w = ~nonmux_w
                   | (access_type_select == ACC_CTRL)
                   | (access_type_select == ACC_DATA);

  assign ctl_w.acc         = access_type_select;
  assign ctl_w.read        = host_read_not_write;
  assign ctl_w.second_half = half_w & host_data_in[HWORD_ID_BIT];
  assign ctl_w.be          = ~host_byte_enables_n;

  assign word_done_w = ~half_w | ctl_q.second_half;
  assign incr_w      = (ctl_q.acc == ACC_DATA_INC) & word_done_w;
  assign step_w      = port_config_reg.address_type_select ? STEP_BYTE : STEP_WORD;
  assign next_addr_w = addr_q + step_w;

  assign rd_addr_w = int_addr(nonmux_w ? {HALF_ZERO, host_address_bus} : addr_q,
                              port_config_reg, page_addr);
  assign wr_addr_w = int_addr(nonmux_w ? {HALF_ZERO, na_q} : addr_q,
                              port_config_reg, page_addr);

  assign ctrl_word_w = (cpu_int_q ? HCR_CPU_INT : ADDR_RESET)
                     | (host_int_q ? HCR_HOST_INT : ADDR_RESET);
  assign wr_word_w = half_w ? {hd_in_q[15:0], hold_lo_q} : hd_in_q;
  assign wr_be_w   = half_w ? {ctl_q.be[1:0], hold_be_q} : ctl_q.be;

  assign busy_w = (state_q == ST_PUSH) | (state_q == ST_RD_WAIT);

  // ------------------------------------------------------------
  // Host pins
  // ------------------------------------------------------------
  assign host_ready_out = ~(~host_chip_select_n & busy_w);
  assign upper_en_w     = ~(half_w & port_config_reg.upper_gpio);
  assign host_data_oe_n = ~{{16{drive_q & upper_en_w}}, {16{drive_q}}};
  assign host_data_out  = hd_out_q;
  assign interrupt_to_host = host_int_q;
  assign host_int_to_cpu   = cpu_int_q;
  assign host_addr_value   = addr_q;

  // ------------------------------------------------------------
  // Shared upper data lines
  // ------------------------------------------------------------
  assign ext_mem_upper_oe_n = {16{~(ext_mem_init_done & ext_mem_drive_req
                                    & ~nonmux_w)}};
  assign ext_mem_upper_blocked  = nonmux_w;
  assign ext_mem_upper_data_out = emu_out_q;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    ctl_d      = ctl_q;
    req_d      = req_q;
    addr_d     = addr_q;
    na_d       = na_q;
    hold_lo_d  = hold_lo_q;
    hold_be_d  = hold_be_q;
    rd_word_d  = rd_word_q;
    hd_out_d   = hd_out_q;
    drive_d    = drive_q;
    cpu_int_d  = cpu_int_q & ~cpu_int_clear;
    host_int_d = host_int_q;
    case (state_q)
      ST_IDLE: begin
        if (start_w) begin
          ctl_d = ctl_w;
          na_d  = host_address_bus;
          if (!allowed_w) begin
            state_d = ST_DRIVE;
          end else if (!ctl_w.read) begin
            state_d = ST_WR_HOLD;
          end else if (access_type_select == ACC_CTRL) begin
            hd_out_d = ctrl_word_w;
            drive_d  = 1'b1;
            state_d  = ST_DRIVE;
          end else if (access_type_select == ACC_ADDR) begin
            if (!half_w) begin
              hd_out_d = addr_q;
            end else if (ctl_w.second_half) begin
              hd_out_d = {HALF_ZERO, addr_q[31:16]};
            end else begin
              hd_out_d = {HALF_ZERO, addr_q[15:0]};
            end
            drive_d = 1'b1;
            state_d = ST_DRIVE;
          end else if (ctl_w.second_half) begin
            hd_out_d = {HALF_ZERO, rd_word_q[31:16]};
            drive_d  = 1'b1;
            state_d  = ST_DRIVE;
          end else begin
            req_d.write = 1'b0;
            req_d.addr  = rd_addr_w;
            req_d.wdata = ADDR_RESET;
            req_d.be    = BE_ALL;
            state_d     = ST_PUSH;
          end
        end
      end
      ST_WR_HOLD: begin
        if (!strobe_w) begin
          state_d = ST_IDLE;
          if (ctl_q.acc == ACC_CTRL) begin
            if (!ctl_q.second_half) begin
              if ((hd_in_q & HCR_CPU_INT) != ADDR_RESET) begin
                cpu_int_d = 1'b1;
              end
              if ((hd_in_q & HCR_HOST_INT) != ADDR_RESET) begin
                host_int_d = 1'b0;
              end
            end
          end else if (ctl_q.acc == ACC_ADDR) begin
            if (!half_w) begin
              addr_d = hd_in_q;
            end else if (ctl_q.second_half) begin
              addr_d[31:16] = hd_in_q[15:0];
            end else begin
              addr_d[15:0] = hd_in_q[15:0];
            end
          end else if (!word_done_w) begin
            hold_lo_d = hd_in_q[15:0];
            hold_be_d = ctl_q.be[1:0];
          end else begin
            req_d.write = 1'b1;
            req_d.addr  = wr_addr_w;
            req_d.wdata = wr_word_w;
            req_d.be    = wr_be_w;
            state_d     = ST_PUSH;
          end
        end
      end
      ST_PUSH: begin
        if (buf_in_ready) begin
          if (req_q.write) begin
            state_d = ST_IDLE;
            if (incr_w) begin
              addr_d = next_addr_w;
            end
          end else begin
            state_d = ST_RD_WAIT;
          end
        end
      end
      ST_RD_WAIT: begin
        if (mem_rsp_valid) begin
          rd_word_d = mem_rsp_rdata;
          hd_out_d  = half_w ? {HALF_ZERO, mem_rsp_rdata[15:0]} : mem_rsp_rdata;
          drive_d   = 1'b1;
          state_d   = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (!strobe_w) begin
          drive_d = 1'b0;
          state_d = ST_IDLE;
          if (ctl_q.read && drive_q && incr_w) begin
            addr_d = next_addr_w;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (cpu_int_to_host_set) begin
      host_int_d = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      ctl_q      <= '0;
      req_q      <= '0;
      addr_q     <= ADDR_RESET;
      na_q       <= HALF_ZERO;
      hold_lo_q  <= HALF_ZERO;
      hold_be_q  <= 2'h0;
      rd_word_q  <= ADDR_RESET;
      hd_out_q   <= ADDR_RESET;
      drive_q    <= 1'b0;
      cpu_int_q  <= 1'b0;
      host_int_q <= 1'b0;
      served_q   <= 1'b0;
      hd_in_q    <= ADDR_RESET;
      emu_out_q  <= HALF_ZERO;
    end else begin
      state_q    <= state_d;
      ctl_q      <= ctl_d;
      req_q      <= req_d;
      addr_q     <= addr_d;
      na_q       <= na_d;
      hold_lo_q  <= hold_lo_d;
      hold_be_q  <= hold_be_d;
      rd_word_q  <= rd_word_d;
      hd_out_q   <= hd_out_d;
      drive_q    <= drive_d;
      cpu_int_q  <= cpu_int_d;
      host_int_q <= host_int_d;
      served_q   <= strobe_w & (served_q | start_w);
      if (strobe_w) begin
        hd_in_q <= host_data_in;
      end
      emu_out_q  <= ext_mem_upper_data;
    end
  end

  // ------------------------------------------------------------
  // Request buffer
  // ------------------------------------------------------------
  uhp_req_buf u_req_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (state_q == ST_PUSH),
    .in_ready  (buf_in_ready),
    .in_data   (req_q),
    .out_valid (mem_req_valid),
    .out_ready (mem_req_ready),
    .out_data  (mem_req)
  );

endmodule
`default_nettype wire

// [verif/uhp_host_port_asserts.sv]
// Pin-level timing checker for the universal host port.
// Assumes it is bound to uhp_host_port and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module uhp_host_port_chk (
  input wire logic                  clock,
  input wire logic                  rst,
  input wire uhp_pkg::uhp_cfg_t     port_config_reg,
  input wire uhp_pkg::uhp_page_t    page_addr,
  input wire logic                  host_chip_select_n,
  input wire logic [1:0]            host_data_strobes,
  input wire logic [31:0]           host_data_oe_n,
  input wire logic                  host_ready_out,
  input wire logic                  interrupt_to_host,
  input wire logic                  cpu_int_to_host_set,
  input wire logic                  host_int_to_cpu,
  input wire logic                  cpu_int_clear,
  input wire uhp_pkg::uhp_mem_req_t mem_req,
  input wire logic                  mem_req_valid,
  input wire logic                  mem_req_ready,
  input wire logic                  ext_mem_init_done,
  input wire logic                  ext_mem_drive_req,
  input wire logic [15:0]           ext_mem_upper_oe_n,
  input wire logic                  ext_mem_upper_blocked
);
  import uhp_pkg::*;
  // ----------------------------------------
  // Decoded pin state
  // ----------------------------------------
  wire logic strb   = !host_chip_select_n && (host_data_strobes[0] != host_data_strobes[1]);
  wire logic hgpio  = !port_config_reg.nonmux_select && !port_config_reg.fullword && port_config_reg.upper_gpio;
  wire logic paged  = port_config_reg.page_mode || port_config_reg.nonmux_select;
  wire logic ext_on = ext_mem_init_done && ext_mem_drive_req && !port_config_reg.nonmux_select;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_drv_beg; $fell(host_data_oe_n[0]); endsequence
  sequence s_drv_end; !host_data_oe_n[0] && !strb; endsequence
  property p_rdy_gate; !host_ready_out |-> !host_chip_select_n; endproperty
  property p_drv_cause; s_drv_beg |-> $past(strb); endproperty
  property p_drv_end; s_drv_end |=> host_data_oe_n[0]; endproperty
  property p_gpio; hgpio |-> &host_data_oe_n[31:16]; endproperty
  property p_lanes; !hgpio |-> host_data_oe_n == {32{host_data_oe_n[0]}}; endproperty
  property p_off; !port_config_reg.enable && host_data_oe_n[0] |=> host_data_oe_n[0]; endproperty
  property p_int_host; cpu_int_to_host_set |=> interrupt_to_host; endproperty
  property p_int_cpu; cpu_int_clear && host_chip_select_n && $past(host_chip_select_n, 2) |=> !host_int_to_cpu;
  endproperty
  property p_hold; mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req); endproperty
  property p_page; mem_req_valid && paged |-> mem_req.addr[31:16] == page_addr; endproperty
  property p_ext_oe; ext_mem_upper_oe_n == ~{16{ext_on}}; endproperty
  property p_block; ext_mem_upper_blocked == port_config_reg.nonmux_select; endproperty
  a_rdy_gate: assert property (p_rdy_gate) else $error("ready low without select");
  a_drv_cause: assert property (p_drv_cause) else $error("drive without strobe");
  a_drv_end: assert property (p_drv_end) else $error("drive outlives strobe");
  a_gpio: assert property (p_gpio) else $error("upper lines driven as gpio");
  a_lanes: assert property (p_lanes) else $error("data lanes enabled apart");
  a_off: assert property (p_off) else $error("drive while disabled");
  a_int_host: assert property (p_int_host) else $error("host interrupt not set");
  a_int_cpu: assert property (p_int_cpu) else $error("cpu interrupt not cleared");
  a_hold: assert property (p_hold) else $error("request changed while stalled");
  a_page: assert property (p_page) else $error("page bits not applied");
  a_ext_oe: assert property (p_ext_oe) else $error("upper line enable wrong");
  a_block: assert property (p_block) else $error("upper block flag wrong");
endmodule
bind uhp_host_port uhp_host_port_chk u_chk (.clock, .rst, .port_config_reg, .page_addr, .host_chip_select_n,
  .host_data_strobes, .host_data_oe_n, .host_ready_out, .interrupt_to_host, .cpu_int_to_host_set,
  .host_int_to_cpu, .cpu_int_clear, .mem_req, .mem_req_valid, .mem_req_ready, .ext_mem_init_done,
  .ext_mem_drive_req, .ext_mem_upper_oe_n, .ext_mem_upper_blocked);
`default_nettype wire

// [verif/uhp_mem_model.sv]
// Behavioural internal memory answering the host port's requests.
// Assumes in-order reads; unwritten words read as the inverted address.
`timescale 1ns/1ps
`default_nettype none
module uhp_mem_model (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire uhp_pkg::uhp_mem_req_t mem_req,
  input  wire logic                  mem_req_valid,
  output logic                       mem_req_ready,
  output logic                       mem_rsp_valid,
  output logic [31:0]                mem_rsp_rdata,
  input  wire logic                  slow,
  input  wire logic                  hold
);
  import uhp_pkg::*;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] pend [$];
  // ----------------------------------------
  // Storage and answers
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_req_ready <= 1'b0;
      mem_rsp_valid <= 1'b0;
      mem_rsp_rdata <= 32'h0000_0000;
    end else begin
      mem_rsp_valid <= 1'b0;
      // Stale answer lines keep toggling
      mem_rsp_rdata <= ~mem_rsp_rdata;
      if (mem_req_valid && mem_req_ready) begin
        if (mem_req.write) begin
          for (int b = 0; b < 4; b++) begin
            if (mem_req.be[b]) mem[mem_req.addr][8*b +: 8] = mem_req.wdata[8*b +: 8];
          end
        end else begin
          pend.push_back(mem.exists(mem_req.addr) ? mem[mem_req.addr] : ~mem_req.addr);
        end
      end
      if (pend.size() > 0 && (!slow || $urandom_range(1) == 1)) begin
        mem_rsp_valid <= 1'b1;
        mem_rsp_rdata <= pend.pop_front();
      end
      mem_req_ready <= !hold && (!slow || $urandom_range(1) == 1);
    end
  end
endmodule
`default_nettype wire

// [verif/tb_uhp_host_port.sv]
// Self-checking bench of uhp_host_port with a memory model behind it.
// Assumes host pins are driven at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, e, s); end end
module tb_uhp_host_port;
  import uhp_pkg::*;
  logic         clock, rst, cs_n, rnw, cset, cclr, idone, dreq, slow, hold, oe_prev;
  logic         rdy, int_h, int_c, mval, mrdy, rval, eu_blk;
  uhp_cfg_t     cfg;
  uhp_page_t    page;
  uhp_mem_req_t mreq, ew;
  logic [1:0]   ds, ds_on, acc;
  logic [3:0]   be_n;
  logic [15:0]  ha, eud, eu_out, eu_oe;
  logic [31:0]  din, dout, oe_n, haddr, rdat, er, a, d;
  logic [31:0]  exp_rd [$];
  uhp_mem_req_t exp_wr [$];
  int           mismatches, check_count, seed;
  uhp_host_port uut (.clock(clock), .rst(rst), .port_config_reg(cfg), .page_addr(page), .host_chip_select_n(cs_n),
    .host_data_strobes(ds), .access_type_select(acc), .host_read_not_write(rnw), .host_byte_enables_n(be_n),
    .host_address_bus(ha), .host_data_in(din), .host_data_out(dout), .host_data_oe_n(oe_n),
    .host_ready_out(rdy), .interrupt_to_host(int_h), .cpu_int_to_host_set(cset), .host_int_to_cpu(int_c),
    .cpu_int_clear(cclr), .host_addr_value(haddr), .mem_req(mreq), .mem_req_valid(mval),
    .mem_req_ready(mrdy), .mem_rsp_valid(rval), .mem_rsp_rdata(rdat), .ext_mem_init_done(idone),
    .ext_mem_drive_req(dreq), .ext_mem_upper_data(eud), .ext_mem_upper_data_out(eu_out),
    .ext_mem_upper_oe_n(eu_oe), .ext_mem_upper_blocked(eu_blk));
  uhp_mem_model u_mem (.clock(clock), .rst(rst), .mem_req(mreq), .mem_req_valid(mval), .mem_req_ready(mrdy),
    .mem_rsp_valid(rval), .mem_rsp_rdata(rdat), .slow(slow), .hold(hold));
  // ----------------------------------------
  // Clock, free pins, result watcher
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(negedge clock) {idone, dreq, eud} <= 18'($urandom);
  always @(negedge clock) begin
    if (oe_prev === 1'b1 && oe_n[0] === 1'b0) begin
      er = exp_rd.size() ? exp_rd.pop_front() : 'x;
      `CHK("read data", er, dout)
    end
    if (mval === 1'b1 && mrdy === 1'b1 && mreq.write === 1'b1) begin
      ew = exp_wr.size() ? exp_wr.pop_front() : 'x;
      `CHK("mem request", ew, mreq)
    end
    if (check_count > 0) `CHK("upper data out", eud, eu_out)
    oe_prev <= oe_n[0];
  end
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("watchdog expired");
    final_report;
  end
  // ----------------------------------------
  // Host cycles and reporting
  // ----------------------------------------
  task automatic hc(input logic [1:0] t, input logic r, input logic [31:0] v, input logic w);
    int n;
    n = 0;
    cs_n = 1'b0;
    ds = ds_on;
    acc = t;
    rnw = r;
    din = v;
    be_n = 4'h0;
    repeat (2) @(negedge clock);
    while ((rdy !== 1'b1 || (w && oe_n[0] !== 1'b0)) && n < 300) begin
      @(negedge clock);
      n++;
    end
    `CHK("host wait", 1'b1, n < 300)
    @(negedge clock);
    cs_n = 1'b1;
    ds = 2'b00;
    din = ~v;
    @(negedge clock);
  endtask
  task automatic hh(input logic [1:0] t, input logic r, input logic id, input logic [15:0] lo);
    hc(t, r, {15'h0000, id, lo}, r);
  endtask
  task automatic done(input string s);
    int n;
    n = 0;
    while ((exp_rd.size() + exp_wr.size() > 0 || mval === 1'b1) && n < 400) begin
      @(negedge clock);
      n++;
    end
    `CHK("drained", 1'b1, n < 400)
    $display("test %s finished", s);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    seed = $urandom(32'h7122_1981);
    rst = 1'b1;
    {cs_n, rnw, cset, cclr, slow, hold, oe_prev} = 7'h41;
    {idone, dreq, eud, ha, page, be_n, din} = '0;
    {ds, acc, ds_on} = 6'h01;
    cfg = 6'h26;
    mismatches = 0;
    check_count = 0;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    a = $urandom & 32'hFFFF_FFF0;
    d = $urandom;
    hc(ACC_ADDR, 1'b0, a, 1'b0);
    `CHK("address reg", a, haddr)
    exp_wr.push_back({1'b1, a, d, BE_ALL});
    hc(ACC_DATA, 1'b0, d, 1'b0);
    exp_rd.push_back(d);
    hc(ACC_DATA, 1'b1, ~d, 1'b1);
    hold = 1'b1;
    for (int i = 0; i < 3; i++) begin
      exp_wr.push_back({1'b1, a + STEP_BYTE * i, d + i, BE_ALL});
      hc(ACC_DATA_INC, 1'b0, d + i, 1'b0);
    end
    repeat (4) @(negedge clock);
    `CHK("stalled request", 1'b1, mval)
    hold = 1'b0;
    slow = 1'b1;
    for (int i = 3; i < 5; i++) begin
      exp_rd.push_back(~(a + STEP_BYTE * i));
      hc(ACC_DATA_INC, 1'b1, 32'h0000_0000, 1'b1);
    end
    `CHK("autoinc address", a + 32'h0000_0014, haddr)
    done("fullword");
    cfg.address_type_select = 1'b0;
    ds_on = 2'b10;
    a = $urandom & 32'h00FF_FFFF;
    hc(ACC_ADDR, 1'b0, a, 1'b0);
    for (int i = 0; i < 2; i++) begin
      exp_wr.push_back({1'b1, (a + STEP_WORD * i) << 2, d ^ i, BE_ALL});
      hc(i ? ACC_DATA : ACC_DATA_INC, 1'b0, d ^ i, 1'b0);
    end
    `CHK("word address", a + STEP_WORD, haddr)
    done("word address");
    cfg = 6'h36;
    ds_on = 2'b01;
    page = 16'($urandom);
    a = $urandom;
    hc(ACC_ADDR, 1'b0, a, 1'b0);
    exp_wr.push_back({1'b1, page, a[15:0], d, BE_ALL});
    hc(ACC_DATA, 1'b0, d, 1'b0);
    done("page");
    cfg = 6'h23;
    a = $urandom & 32'hFFFF_FFFC;
    hh(ACC_ADDR, 1'b0, 1'b0, a[15:0]);
    hh(ACC_ADDR, 1'b0, 1'b1, a[31:16]);
    `CHK("half address", a, haddr)
    exp_wr.push_back({1'b1, a, d, BE_ALL});
    hh(ACC_DATA, 1'b0, 1'b0, d[15:0]);
    hh(ACC_DATA, 1'b0, 1'b1, d[31:16]);
    for (int g = 0; g < 2; g++) begin
      exp_rd.push_back({HALF_ZERO, d[15:0]});
      exp_rd.push_back({HALF_ZERO, d[31:16]});
      hh(ACC_DATA, 1'b1, 1'b0, HALF_ZERO);
      hh(ACC_DATA, 1'b1, 1'b1, HALF_ZERO);
      cfg.upper_gpio = ~cfg.upper_gpio;
    end
    done("half-word");
    cfg = 6'h26;
    hc(ACC_CTRL, 1'b0, HCR_CPU_INT, 1'b0);
    repeat (2) @(negedge clock);
    `CHK("int to cpu", 1'b1, int_c)
    cclr = 1'b1;
    @(negedge clock);
    cclr = 1'b0;
    cset = 1'b1;
    @(negedge clock);
    cset = 1'b0;
    `CHK("int to cpu cleared", 1'b0, int_c)
    `CHK("int to host", 1'b1, int_h)
    exp_rd.push_back(HCR_HOST_INT);
    hc(ACC_CTRL, 1'b1, 32'h0000_0000, 1'b1);
    hc(ACC_CTRL, 1'b0, HCR_HOST_INT, 1'b0);
    @(negedge clock);
    `CHK("int to host cleared", 1'b0, int_h)
    done("control");
    cfg = 6'h2E;
    ha = 16'($urandom) & 16'hFFFC;
    exp_wr.push_back({1'b1, page, ha, d, BE_ALL});
    hc(ACC_DATA, 1'b0, d, 1'b0);
    a = haddr;
    hc(ACC_DATA_INC, 1'b0, ~d, 1'b0);
    hc(ACC_ADDR, 1'b0, ~d, 1'b0);
    hc(ACC_ADDR, 1'b1, ~d, 1'b0);
    hc(ACC_DATA_INC, 1'b1, ~d, 1'b0);
    `CHK("refused address", a, haddr)
    exp_rd.push_back(d);
    hc(ACC_DATA, 1'b1, 32'h0000_0000, 1'b1);
    `CHK("upper pins blocked", 1'b1, eu_blk)
    done("non-muxed");
    cfg.enable = 1'b0;
    hc(ACC_DATA, 1'b0, d, 1'b0);
    hc(ACC_DATA, 1'b1, d, 1'b0);
    cfg.enable = 1'b1;
    ds_on = 2'b11;
    hc(ACC_DATA, 1'b1, d, 1'b0);
    hc(ACC_DATA, 1'b0, d, 1'b0);
    ds_on = 2'b01;
    repeat (8) @(negedge clock);
    done("ignored strobes");
    final_report;
  end
endmodule
`default_nettype wire
